// [rtl/telemetry_regs.svh]
// Telemetry register map, command codes and timing constants of the readout
`ifndef TELEMETRY_REGS_SVH
`define TELEMETRY_REGS_SVH
`define DEV_ADDR_WRITE 8'h30
`define DEV_ADDR_READ 8'h31
`define CMD_TELEMETRY_SELECT 8'h80
`define CMD_CC_CODE 8'h18
`define CMD_LINE_SENSE 8'h1c
`define LINE_SENSE_ENABLE 8'h01
`define TEL_CURRENT_NOW 8'h10
`define TEL_VOLTAGE_NOW 8'h12
`define TEL_STATUS 8'h14
`define TEL_CURRENT_AVG 8'h18
`define TEL_VOLTAGE_AVG 8'h1a
`define TEL_PRIMARY_SUM 8'h2a
`define TEL_RECTIFIER_SUM 8'h2c
`define TEL_CAL_OFFSET 8'h2e
`define TEL_ADDR_STEP 8'h02
`define STATUS_READY_BIT 12
`define CUR_PARITY_BIT 15
`define CAL_SIGN_BIT 3
`define AVG_LOG2_DEPTH 4
`define LS_SAMPLES 16
`define PRI_DELAY_TICKS 4
`define REFRESH_US 100
`define CLK_PERIOD_NS 10
`define TICK_NS 85
`define REFRESH_CYCLES ((`REFRESH_US * 1000) / `CLK_PERIOD_NS)
`endif

// [rtl/telemetry_pkg.sv]
// Shared types of the telemetry readout
`default_nettype none
package telemetry_pkg;
  typedef enum logic [6:0] {
    s_idle = 7'h01,
    s_addr = 7'h02,
    s_addr_ack = 7'h04,
    s_write = 7'h08,
    s_write_ack = 7'h10,
    s_read = 7'h20,
    s_read_ack = 7'h40
  } i2c_state_e;
endpackage : telemetry_pkg
`default_nettype wire

// [rtl/rolling_average.sv]
// Sixteen-deep rolling average of one measurement channel
`default_nettype none
`include "telemetry_regs.svh"
module rolling_average #(
  parameter int W = 12,
  parameter int LOG2_DEPTH = `AVG_LOG2_DEPTH
) (
  input wire logic i_core_clk, // Core clock
  input wire logic i_arst_n, // Async reset, active low
  input wire logic i_sample_en, // One-cycle pulse, new sample
  input wire logic i_clear, // Level, forces history to zero
  input wire logic [W-1:0] i_sample, // Newest sample
  output logic [W-1:0] o_average // Mean of the held samples
);
  localparam int DEPTH = 1 << LOG2_DEPTH;
  localparam int SW = W + LOG2_DEPTH;
  logic [W-1:0] hist_reg [DEPTH];
  logic [LOG2_DEPTH-1:0] idx_reg;
  logic [SW-1:0] sum_reg;
  logic [SW-1:0] sum_next;

  // Running sum swaps the oldest sample for the newest
  assign sum_next = sum_reg + SW'(i_sample) - SW'(hist_reg[idx_reg]);

  // History ring, sum and output; the clear empties everything
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int k = 0; k < DEPTH; k++) begin
        hist_reg[k] <= '0;
      end
      idx_reg <= '0;
      sum_reg <= '0;
      o_average <= '0;
    end else if (i_clear) begin
      for (int k = 0; k < DEPTH; k++) begin
        hist_reg[k] <= '0;
      end
      idx_reg <= '0;
      sum_reg <= '0;
      o_average <= '0;
    end else if (i_sample_en) begin
      hist_reg[idx_reg] <= i_sample;
      idx_reg <= idx_reg + 1'b1;
      sum_reg <= sum_next;
      o_average <= sum_next[SW-1:LOG2_DEPTH];
    end
  end

  a_avg_clear: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_clear |=> (o_average == '0) && (sum_reg == '0))
    else $error("Average not zero after clear");
endmodule : rolling_average
`default_nettype wire

// [rtl/on_time_accumulator.sv]
// Sums conduction times over a fixed number of switching samples
`default_nettype none
`include "telemetry_regs.svh"
module on_time_accumulator #(
  parameter int W = 16,
  parameter int RUN_W = 10,
  parameter int SAMPLES = `LS_SAMPLES,
  parameter logic [RUN_W-1:0] DELAY_TICKS = '0
) (
  input wire logic i_core_clk, // Core clock
  input wire logic i_arst_n, // Async reset, active low
  input wire logic i_start, // Pulse, restart accumulation
  input wire logic i_abort, // Level, stop and stay idle
  input wire logic i_tick, // Pulse, one time tick
  input wire logic i_conduct, // Level, switch conducting
  output logic [W-1:0] o_sum, // Completed total
  output logic o_done // Pulse, total just loaded
);
  localparam int SC_W = $clog2(SAMPLES);
  logic conduct_prev_reg;
  logic seen_rise_reg;
  logic active_reg;
  logic [RUN_W-1:0] run_reg;
  logic [SC_W-1:0] sample_cnt_reg;
  logic [W-1:0] acc_reg;
  logic [W-1:0] acc_next;
  logic rise;
  logic fall;

  assign rise = i_conduct & ~conduct_prev_reg;
  assign fall = conduct_prev_reg & ~i_conduct;
  // Each sample adds its ticks plus the fixed path delay
  assign acc_next = acc_reg + W'(run_reg) + W'(DELAY_TICKS);

  // Tick count of the conduction interval in progress
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      conduct_prev_reg <= 1'b0;
      run_reg <= '0;
    end else begin
      conduct_prev_reg <= i_conduct;
      if (rise) begin
        run_reg <= '0;
      end else if (i_conduct && i_tick) begin
        run_reg <= run_reg + 1'b1;
      end
    end
  end

  // Sample sequencing; partial intervals before the first rise are skipped
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      active_reg <= 1'b0;
      seen_rise_reg <= 1'b0;
      sample_cnt_reg <= '0;
      acc_reg <= '0;
      o_sum <= '0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_abort) begin
        active_reg <= 1'b0;
      end else if (i_start) begin
        active_reg <= 1'b1;
        seen_rise_reg <= 1'b0;
        sample_cnt_reg <= '0;
        acc_reg <= '0;
      end else if (active_reg) begin
        if (rise) begin
          seen_rise_reg <= 1'b1;
        end
        if (fall && seen_rise_reg) begin
          acc_reg <= acc_next;
          sample_cnt_reg <= sample_cnt_reg + 1'b1;
          if (sample_cnt_reg == SC_W'(SAMPLES - 1)) begin
            o_sum <= acc_next;
            o_done <= 1'b1;
            active_reg <= 1'b0;
          end
        end
      end
    end
  end

  a_done_count: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_done |-> $past(sample_cnt_reg) == SC_W'(SAMPLES - 1) && $past(fall) && !active_reg)
    else $error("Sum completed at wrong sample count");
endmodule : on_time_accumulator
`default_nettype wire

// [rtl/telemetry_measurement_readout.sv]
// Telemetry readout top: serial slave, measurement refresh and line-sense control
`default_nettype none
`include "telemetry_regs.svh"
module telemetry_measurement_readout #(
  parameter int CUR_W = 9,
  parameter int VOLT_W = 12,
  parameter int REFRESH_CYCLES = `REFRESH_CYCLES
) (
  input wire logic i_core_clk, // 100 MHz core clock
  input wire logic i_arst_n, // Async reset, active low
  input wire logic i_scl, // Serial clock from host
  input wire logic i_sda, // Serial data wire level
  output logic o_sda_out, // Serial data drive value, always low
  output logic o_sda_oe, // High while pulling data low
  input wire logic [CUR_W-1:0] i_current_count, // Measured current count
  input wire logic [VOLT_W-1:0] i_voltage_count, // Measured voltage, 10 mV steps
  input wire logic i_bus_switch_open, // Series load switch open
  input wire logic i_sync_rect_enable, // Synchronous rectifier enabled
  input wire logic i_primary_conducting, // Primary switch on
  input wire logic i_rectifier_conducting, // Rectifier conducting
  input wire logic [3:0] i_cal_offset_trim, // Factory offset, sign and magnitude
  input wire logic i_supply_below_reset, // Controller supply under reset level
  output logic [15:0] o_cc_code, // Constant-current code from host
  output logic o_line_sense_busy // Accumulation in progress
);
  localparam int RC_W = $clog2(REFRESH_CYCLES);
  localparam int PH_W = 7;
  telemetry_pkg::i2c_state_e state_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [3:0] bit_cnt_reg;
  logic [7:0] rx_shift_reg;
  logic [7:0] tx_shift_reg;
  logic [7:0] next_byte;
  logic [1:0] byte_idx_reg;
  logic tx_high_reg;
  logic [15:0] tx_word_reg;
  logic [15:0] sel_word;
  logic [15:0] next_word;
  logic [7:0] cmd_reg;
  logic [7:0] tel_addr_reg;
  logic [7:0] cc_low_reg;
  logic wr_strobe;
  logic rd_advance;
  logic ls_start;
  logic [RC_W-1:0] refresh_cnt_reg;
  logic refresh_en;
  logic [CUR_W-1:0] cur_now_reg;
  logic [CUR_W-1:0] cur_avg;
  logic [VOLT_W-1:0] volt_now_reg;
  logic [VOLT_W-1:0] volt_avg;
  logic [PH_W-1:0] phase_reg;
  logic tick_en;
  logic ls_busy_reg;
  logic ls_ready_reg;
  logic pri_seen_reg;
  logic rec_seen_reg;
  logic pri_done;
  logic rec_done;
  logic [15:0] pri_sum;
  logic [15:0] rec_sum;
  logic [15:0] pri_sum_reg;
  logic [15:0] rec_sum_reg;

  // Current word: count in the low bits, odd parity over the rest of the high byte
  function automatic logic [15:0] current_word(input logic [CUR_W-1:0] count);
    logic [15:0] w;
    w = 16'(count);
    w[`CUR_PARITY_BIT] = ~^w[`CUR_PARITY_BIT-1:8];
    return w;
  endfunction : current_word

  // Telemetry read map; unmapped addresses read as zero
  function automatic logic [15:0] read_word(input logic [7:0] addr);
    logic [15:0] w;
    w = 16'h0000;
    case (addr)
      `TEL_CURRENT_NOW: w = current_word(cur_now_reg);
      `TEL_VOLTAGE_NOW: w = 16'(volt_now_reg);
      `TEL_STATUS: w[`STATUS_READY_BIT] = ls_ready_reg;
      `TEL_CURRENT_AVG: w = current_word(cur_avg);
      `TEL_VOLTAGE_AVG: w = 16'(volt_avg);
      `TEL_PRIMARY_SUM: w = pri_sum_reg;
      `TEL_RECTIFIER_SUM: w = rec_sum_reg;
      `TEL_CAL_OFFSET: w[`CAL_SIGN_BIT:0] = i_cal_offset_trim;
      default: w = 16'h0000;
    endcase
    return w;
  endfunction : read_word

  // Bus condition detection on the sampled pins
  assign scl_rise = i_scl & ~scl_prev_reg;
  assign scl_fall = scl_prev_reg & ~i_scl;
  assign start_cond = scl_prev_reg & i_scl & sda_prev_reg & ~i_sda;
  assign stop_cond = scl_prev_reg & i_scl & ~sda_prev_reg & i_sda;
  assign o_sda_out = 1'b0;
  assign o_line_sense_busy = ls_busy_reg;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= i_scl;
      sda_prev_reg <= i_sda;
    end
  end

  // Byte strobes and the word to send next
  assign wr_strobe = (state_reg == telemetry_pkg::s_write) && scl_fall && (bit_cnt_reg == 4'h8);
  assign rd_advance = (state_reg == telemetry_pkg::s_read_ack) && scl_fall && tx_high_reg;
  assign ls_start = wr_strobe && (byte_idx_reg == 2'h1) && (cmd_reg == `CMD_LINE_SENSE)
                    && (rx_shift_reg == `LINE_SENSE_ENABLE);
  always_comb sel_word = read_word(tel_addr_reg); // Follows every source the map reads
  always_comb next_word = read_word(tel_addr_reg + `TEL_ADDR_STEP);
  assign next_byte = tx_high_reg ? next_word[7:0] : tx_word_reg[15:8];

  // Serial slave sequencer; only data is ever driven, always low
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= telemetry_pkg::s_idle;
      bit_cnt_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
      tx_shift_reg <= 8'h00;
      tx_word_reg <= 16'h0000;
      tx_high_reg <= 1'b0;
      byte_idx_reg <= 2'h0;
      o_sda_oe <= 1'b0;
    end else if (i_supply_below_reset || stop_cond) begin
      state_reg <= telemetry_pkg::s_idle;
      o_sda_oe <= 1'b0;
    end else if (start_cond) begin
      state_reg <= telemetry_pkg::s_addr;
      bit_cnt_reg <= 4'h0;
      byte_idx_reg <= 2'h0;
      o_sda_oe <= 1'b0;
    end else begin
      unique case (state_reg)
        telemetry_pkg::s_idle: begin
          o_sda_oe <= 1'b0;
        end
        telemetry_pkg::s_addr, telemetry_pkg::s_write: begin
          if (scl_rise && bit_cnt_reg != 4'h8) begin
            rx_shift_reg <= {rx_shift_reg[6:0], i_sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == telemetry_pkg::s_write) begin
              o_sda_oe <= 1'b1;
              state_reg <= telemetry_pkg::s_write_ack;
            end else if (rx_shift_reg == `DEV_ADDR_WRITE || rx_shift_reg == `DEV_ADDR_READ) begin
              o_sda_oe <= 1'b1;
              state_reg <= telemetry_pkg::s_addr_ack;
            end else begin
              state_reg <= telemetry_pkg::s_idle;
            end
          end
        end
        telemetry_pkg::s_addr_ack: begin
          if (scl_fall && rx_shift_reg[0]) begin
            tx_word_reg <= sel_word;
            tx_shift_reg <= sel_word[7:0];
            tx_high_reg <= 1'b0;
            o_sda_oe <= ~sel_word[7];
            bit_cnt_reg <= 4'h0;
            state_reg <= telemetry_pkg::s_read;
          end else if (scl_fall) begin
            o_sda_oe <= 1'b0;
            state_reg <= telemetry_pkg::s_write;
          end
        end
        telemetry_pkg::s_write_ack: begin
          if (scl_fall) begin
            o_sda_oe <= 1'b0;
            state_reg <= telemetry_pkg::s_write;
            if (byte_idx_reg != 2'h3) begin
              byte_idx_reg <= byte_idx_reg + 2'h1;
            end
          end
        end
        telemetry_pkg::s_read: begin
          if (scl_fall && bit_cnt_reg == 4'h7) begin
            o_sda_oe <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg <= telemetry_pkg::s_read_ack;
          end else if (scl_fall) begin
            o_sda_oe <= ~tx_shift_reg[6];
            tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end
        telemetry_pkg::s_read_ack: begin
          if (scl_rise && i_sda) begin
            state_reg <= telemetry_pkg::s_idle;
          end else if (scl_fall) begin
            if (tx_high_reg) begin
              tx_word_reg <= next_word;
            end
            tx_high_reg <= ~tx_high_reg;
            tx_shift_reg <= next_byte;
            o_sda_oe <= ~next_byte[7];
            state_reg <= telemetry_pkg::s_read;
          end
        end
      endcase
    end
  end

  // Command bytes: telemetry select, constant-current code low then high
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cmd_reg <= 8'h00;
      tel_addr_reg <= 8'h00;
      cc_low_reg <= 8'h00;
      o_cc_code <= 16'h0000;
    end else if (wr_strobe) begin
      if (byte_idx_reg == 2'h0) begin
        cmd_reg <= rx_shift_reg;
      end else if (cmd_reg == `CMD_TELEMETRY_SELECT && byte_idx_reg == 2'h1) begin
        tel_addr_reg <= rx_shift_reg;
      end else if (cmd_reg == `CMD_CC_CODE && byte_idx_reg == 2'h1) begin
        cc_low_reg <= rx_shift_reg;
      end else if (cmd_reg == `CMD_CC_CODE && byte_idx_reg == 2'h2) begin
        o_cc_code <= {rx_shift_reg, cc_low_reg};
      end
    end else if (rd_advance) begin
      tel_addr_reg <= tel_addr_reg + `TEL_ADDR_STEP;
    end
  end

  // Measurement refresh divider
  assign refresh_en = (refresh_cnt_reg == RC_W'(REFRESH_CYCLES - 1));
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      refresh_cnt_reg <= '0;
    end else if (refresh_en) begin
      refresh_cnt_reg <= '0;
    end else begin
      refresh_cnt_reg <= refresh_cnt_reg + 1'b1;
    end
  end

  // Instantaneous values latch once per refresh period
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cur_now_reg <= '0;
      volt_now_reg <= '0;
    end else if (refresh_en) begin
      cur_now_reg <= i_current_count;
      volt_now_reg <= i_voltage_count;
    end
  end

  rolling_average #(.W(CUR_W), .LOG2_DEPTH(`AVG_LOG2_DEPTH)) u_current_avg (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_sample_en(refresh_en & ~i_bus_switch_open),
    .i_clear(i_bus_switch_open),
    .i_sample(i_current_count),
    .o_average(cur_avg)
  );

  rolling_average #(.W(VOLT_W), .LOG2_DEPTH(`AVG_LOG2_DEPTH)) u_voltage_avg (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_sample_en(refresh_en & ~i_bus_switch_open),
    .i_clear(i_bus_switch_open),
    .i_sample(i_voltage_count),
    .o_average(volt_avg)
  );

  // 85 ns ticks from the 10 ns clock, spaced 8 or 9 cycles to keep the mean exact
  assign tick_en = (phase_reg >= PH_W'(`TICK_NS - `CLK_PERIOD_NS));
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase_reg <= '0;
    end else if (tick_en) begin
      phase_reg <= phase_reg + PH_W'(`CLK_PERIOD_NS) - PH_W'(`TICK_NS);
    end else begin
      phase_reg <= phase_reg + PH_W'(`CLK_PERIOD_NS);
    end
  end

  on_time_accumulator #(.W(16), .RUN_W(10), .SAMPLES(`LS_SAMPLES),
    .DELAY_TICKS(10'(`PRI_DELAY_TICKS))) u_primary_acc (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_start(ls_start & i_sync_rect_enable),
    .i_abort(~i_sync_rect_enable),
    .i_tick(tick_en),
    .i_conduct(i_primary_conducting),
    .o_sum(pri_sum),
    .o_done(pri_done)
  );

  on_time_accumulator #(.W(16), .RUN_W(10), .SAMPLES(`LS_SAMPLES),
    .DELAY_TICKS(10'h000)) u_rectifier_acc (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_start(ls_start & i_sync_rect_enable),
    .i_abort(~i_sync_rect_enable),
    .i_tick(tick_en),
    .i_conduct(i_rectifier_conducting),
    .o_sum(rec_sum),
    .o_done(rec_done)
  );

  // Sum registers stay stale until a commanded accumulation completes
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pri_sum_reg <= 16'h0000;
      rec_sum_reg <= 16'h0000;
    end else begin
      if (pri_done) begin
        pri_sum_reg <= pri_sum;
      end
      if (rec_done) begin
        rec_sum_reg <= rec_sum;
      end
    end
  end

  // Line-sense progress and ready flag
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ls_busy_reg <= 1'b0;
      ls_ready_reg <= 1'b0;
      pri_seen_reg <= 1'b0;
      rec_seen_reg <= 1'b0;
    end else if (!i_sync_rect_enable) begin
      ls_busy_reg <= 1'b0;
      ls_ready_reg <= 1'b0;
      pri_seen_reg <= 1'b0;
      rec_seen_reg <= 1'b0;
    end else if (ls_start) begin
      ls_busy_reg <= 1'b1;
      ls_ready_reg <= 1'b0;
      pri_seen_reg <= 1'b0;
      rec_seen_reg <= 1'b0;
    end else if (ls_busy_reg) begin
      pri_seen_reg <= pri_seen_reg | pri_done;
      rec_seen_reg <= rec_seen_reg | rec_done;
      if ((pri_seen_reg | pri_done) && (rec_seen_reg | rec_done)) begin
        ls_busy_reg <= 1'b0;
        ls_ready_reg <= 1'b1;
      end
    end
  end

  a_supply_silent: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_supply_below_reset |=> !o_sda_oe && state_reg == telemetry_pkg::s_idle)
    else $error("Serial data driven while supply is low");
  a_ready_rises: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    $rose(ls_ready_reg) |-> $past(ls_busy_reg) && !ls_busy_reg
    && $past(pri_seen_reg | pri_done) && $past(rec_seen_reg | rec_done))
    else $error("Ready set without completed accumulation");
  a_restart_clears: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    ls_start && i_sync_rect_enable |=> ls_busy_reg && !ls_ready_reg)
    else $error("Line-sense restart did not clear ready");
  a_sr_off_idle: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    !i_sync_rect_enable |=> !ls_busy_reg && !ls_ready_reg)
    else $error("Line sensing active while rectifier disabled");
  a_sums_stale: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    !ls_busy_reg |=> $stable(pri_sum_reg) && $stable(rec_sum_reg))
    else $error("On-time sums changed without a command");
  a_now_latch: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    refresh_en |=> cur_now_reg == $past(i_current_count) && volt_now_reg == $past(i_voltage_count))
    else $error("Measurement not latched on refresh");
  a_now_hold: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    !refresh_en |=> $stable(cur_now_reg) && $stable(volt_now_reg))
    else $error("Measurement changed between refreshes");
  a_low_first: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    state_reg == telemetry_pkg::s_addr_ack && scl_fall && rx_shift_reg[0]
    && !i_supply_below_reset && !stop_cond && !start_cond
    |=> !tx_high_reg && tx_shift_reg == $past(sel_word[7:0]))
    else $error("Read did not start with the low byte");
endmodule : telemetry_measurement_readout
`default_nettype wire

// [tb/i2c_host_model.sv]
// Serial host model that issues telemetry reads and command writes
`default_nettype none
module i2c_host_model (
  input wire logic i_clk, // Core clock, pacing only
  input wire logic i_sda, // Resolved data wire
  output logic o_scl, // Serial clock drive
  output logic o_sda_pull, // High while pulling data low
  output logic o_vld, // Pulse, word received
  output logic [15:0] o_word // Last word read
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
    o_vld = 1'b0;
    o_word = 16'h0000;
  end
  // Four core cycles between wire changes; clock low lasts twice its high time
  task automatic half;
    repeat (4) @(negedge i_clk);
  endtask : half
  task automatic start;
    o_sda_pull = 1'b0;
    half();
    o_scl = 1'b1;
    half();
    o_sda_pull = 1'b1;
    half();
    o_scl = 1'b0;
    half();
  endtask : start
  // One bit: data set while clock low, sampled just before the fall
  task automatic bitx(input logic b, output logic r);
    o_sda_pull = ~b;
    half();
    o_scl = 1'b1;
    half();
    r = i_sda;
    o_scl = 1'b0;
    half();
  endtask : bitx
  task automatic wbyte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
  endtask : wbyte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(last, r);
  endtask : rbyte
  task automatic stop;
    o_sda_pull = 1'b1;
    half();
    o_scl = 1'b1;
    half();
    o_sda_pull = 1'b0;
    half();
  endtask : stop
  // Select address, repeated start, two bytes, low byte first
  task automatic rd_word(input logic [7:0] a);
    logic [7:0] lo, hi;
    start();
    wbyte(8'h30);
    wbyte(8'h80);
    wbyte(a);
    start();
    wbyte(8'h31);
    rbyte(1'b0, lo);
    rbyte(1'b1, hi);
    stop();
    o_word = {hi, lo};
    o_vld = 1'b1;
    @(negedge i_clk);
    o_vld = 1'b0;
  endtask : rd_word
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic two);
    start();
    wbyte(8'h30);
    wbyte(c);
    wbyte(d[7:0]);
    if (two) wbyte(d[15:8]);
    stop();
  endtask : wr
endmodule : i2c_host_model
`default_nettype wire

// [tb/tb_telemetry_measurement_readout.sv]
// Self-checking bench of the telemetry readout
`default_nettype none
module tb_telemetry_measurement_readout;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, arst_n = 1'b0, open_sw = 1'b0, sr_en = 1'b1, pri = 1'b0, rec = 1'b0;
  logic low_sup = 1'b0, scl, pull, oe, sdo, busy, w_vld;
  logic [8:0] cur = '0;
  logic [11:0] volt = '0;
  logic [3:0] trim = 4'h0;
  logic [15:0] cc, w, code, rnd = 16'hc8a2;
  logic [15:0] exp_q[$];
  int error_cnt = 0, checks_done = 0, cyc = 0;
  wire logic sda = ~(pull | oe);
  i2c_host_model h (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull), .o_vld(w_vld),
    .o_word(w));
  telemetry_measurement_readout #(.REFRESH_CYCLES(50)) dut_u (.i_core_clk(clk),
    .i_arst_n(arst_n), .i_scl(scl), .i_sda(sda), .o_sda_out(sdo), .o_sda_oe(oe),
    .i_current_count(cur), .i_voltage_count(volt), .i_bus_switch_open(open_sw),
    .i_sync_rect_enable(sr_en), .i_primary_conducting(pri), .i_rectifier_conducting(rec),
    .i_cal_offset_trim(trim), .i_supply_below_reset(low_sup), .o_cc_code(cc),
    .o_line_sense_busy(busy));
  always #5 clk = ~clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic end_sim;
    if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  // Note the expectation, then run the read
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    h.rd_word(a);
  endtask : rd
  // Line-sense command, then pulses whose high times span whole tick pairs
  // (17 cycles hold two ticks), so primary counts 4 and rectifier 2 ticks a sample
  task automatic line_sense(input int n);
    h.wr(8'h1c, 16'h0001, 1'b0);
    repeat (n) begin
      pri = 1'b1;
      repeat (35) @(negedge clk);
      pri = 1'b0;
      rec = 1'b1;
      repeat (18) @(negedge clk);
      rec = 1'b0;
      repeat (10) @(negedge clk);
    end
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clk);
  endtask : line_sense
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Each word seen is compared with the oldest note
  always @(posedge clk) if (w_vld === 1'b1) check(w, exp_q.pop_front());
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    rnd = lfsr(rnd);
    cur = rnd[8:0];
    volt = rnd[15:4];
    trim = rnd[3:0];
    repeat (60) @(negedge clk);
    rd(8'h10, {~cur[8], 6'h00, cur});
    rd(8'h12, {4'h0, volt});
    rd(8'h2e, {12'h000, trim});
    rd(8'h18, {~cur[8], 6'h00, cur});
    rd(8'h1a, {4'h0, volt});
    rd(8'h2a, 16'h0000);
    open_sw = 1'b1;
    rd(8'h18, 16'h8000);
    rd(8'h1a, 16'h0000);
    rnd = lfsr(rnd);
    code = trim[3] ? rnd - trim[2:0] : rnd + trim[2:0];
    h.wr(8'h18, code, 1'b1);
    check(cc, code);
    h.wr(8'h18, ~code, 1'b0);
    check(cc, code);
    line_sense(20);
    rd(8'h14, 16'h1000);
    // Sixteen samples: primary 4 ticks plus 4 delay each, rectifier 2; no zero-volt time added
    rd(8'h2a, 16'h0080);
    rd(8'h2c, 16'h0020);
    line_sense(0);
    rd(8'h14, 16'h0000);
    rd(8'h2a, 16'h0080);
    sr_en = 1'b0;
    repeat (3) @(negedge clk);
    check({15'h0000, busy}, 16'h0000);
    low_sup = 1'b1;
    rd(8'h10, 16'hffff);
    end_sim();
  end
endmodule : tb_telemetry_measurement_readout
`default_nettype wire
